// *** core/fsa_defines.vh ***
`ifndef FSA_DEFINES_VH
`define FSA_DEFINES_VH
// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define FSA_IDX_FIRST 8'h0b
`define FSA_IDX_MODE 8'h0d
`define FSA_IDX_FIFO_SEL 8'h0e
`define FSA_IDX_LIST 8'h0f
`define FSA_IDX_SLOT_SEL 8'h10
`define FSA_IDX_STATUS 8'h1c
`define FSA_IDX_SLOT 8'hd0
`define FSA_IDX_CHANNEL 8'hf4
`define FSA_IDX_CHMASK 8'hf5
`define FSA_IDX_NEXT 8'hf7
`define FSA_IDX_CTRL 8'hfa
`define FSA_IDX_SUBCH 8'hfb
// ----------------------------------------------------------------
// field codes and reset values
// ----------------------------------------------------------------
`define FSA_MODE_SEQ 2'h3
`define FSA_FLOW_CROSS 3'h6
`define FSA_ROUTE_AB 2'h2
`define FSA_END_BIT 7
`define FSA_MODE_RST 2'h0
`define FSA_SUBCH_RST 8'h00
`define FSA_LIST_LAST 5'h1f
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSA_FRAME_NS 125000
`define FSA_CLK_NS 10
`define FSA_FRAME_CYC (`FSA_FRAME_NS / `FSA_CLK_NS)
`endif

// *** core/fsa_mem.v ***
`timescale 1ns/10ps
`default_nettype none
// 32-word table, one write port, two registered read ports
module fsa_mem #(
  parameter W = 8,
  parameter RST = 0
) (
  input wire aclk,
  input wire we,
  input wire [4:0] waddr,
  input wire [W-1:0] wdata,
  input wire [4:0] raddr_a,
  output reg [W-1:0] rdata_a,
  input wire [4:0] raddr_b,
  output reg [W-1:0] rdata_b
);
  reg [W-1:0] mem [0:31];
  integer k;
  // ------------------------------------------------------------
  // storage and read registers
  // ------------------------------------------------------------
  initial
  begin
    for (k = 0; k < 32; k = k + 1)
      mem[k] = RST[W-1:0];
  end
  // write then registered reads
  always @(posedge aclk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule // fsa_mem
`default_nettype wire

// *** core/fsa_exchanger.v ***
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defines.vh"
// tx-rx exchanger for a pcm to line interface cross connection
module fsa_exchanger (
  input wire aclk,
  input wire aresetn,
  input wire slot_strobe,
  input wire slot_dir,
  input wire [1:0] slot_pin_route,
  input wire cross_ok,
  input wire [7:0] line_rx_data,
  input wire [7:0] serial_data_pin_b,
  output reg [7:0] serial_data_pin_a,
  output reg pin_a_valid,
  output reg [7:0] line_tx_data,
  output reg line_tx_valid,
  output reg [7:0] fifo_rx_data,
  output reg fifo_rx_wr
);
  wire go;
  // framing selection never enters here: always transparent
  assign go = slot_strobe & cross_ok & (slot_pin_route == `FSA_ROUTE_AB);
  // ------------------------------------------------------------
  // direction swap
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_data_pin_a <= 8'h00;
      pin_a_valid <= 1'b0;
      line_tx_data <= 8'h00;
      line_tx_valid <= 1'b0;
      fifo_rx_data <= 8'h00;
      fifo_rx_wr <= 1'b0;
    end
    else
    begin
      pin_a_valid <= go & ~slot_dir;
      line_tx_valid <= go & slot_dir;
      fifo_rx_wr <= go & ~slot_dir;
      if (go && !slot_dir)
      begin
        serial_data_pin_a <= line_rx_data;
        fifo_rx_data <= line_rx_data;
      end
      if (go && slot_dir)
        line_tx_data <= serial_data_pin_b;
    end
  end
endmodule // fsa_exchanger
`default_nettype wire

// *** core/fsa_assigner.v ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defines.vh"
// fifo to switching channel assigner with sequence list walker
module fsa_assigner #(
  parameter FRAME_CYCLES = `FSA_FRAME_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg seq_xfer,
  output reg seq_fifo_dir,
  output reg [3:0] seq_fifo_num,
  output reg seq_chan_dir,
  output reg [3:0] seq_chan,
  output reg [7:0] seq_subch_mask,
  output reg [7:0] seq_chan_mask,
  output reg seq_transparent,
  input wire pcm_slot_strobe,
  input wire [4:0] pcm_slot_idx,
  input wire [7:0] line_rx_data,
  input wire [7:0] serial_data_pin_b,
  output wire [7:0] serial_data_pin_a,
  output wire pin_a_valid,
  output wire [7:0] line_tx_data,
  output wire line_tx_valid,
  output wire [7:0] fifo_rx_data,
  output wire fifo_rx_wr
);
  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_USE = 2'h2;
  localparam S_MSK = 2'h3;
  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  reg [1:0] mode_r;
  reg [4:0] fifo_sel_r, list_idx_r, first_r, slot_sel_r, idx_r, cur_r;
  reg [1:0] state_r;
  reg [15:0] frame_cnt_r;
  reg frame_tick_r;
  reg [15:0] xtx_pend_r;
  reg [15:0] xrx_pend_r;
  reg [15:0] cross_ok_r;
  reg aw_ok_r;
  reg w_ok_r;
  reg [7:0] aw_idx_r;
  reg [31:0] w_data_r;
  reg rd_pend_r;
  reg [7:0] ar_idx_r;
  reg slot_stb_r;
  wire seq_mode;
  wire wr_go;
  wire [4:0] list_sel;
  wire [4:0] seq_list_addr;
  wire [4:0] seq_ctrl_addr;
  wire [4:0] b_chan;
  wire [6:0] b_next, b_ctrl, b_slot;
  wire [7:0] b_subch, b_mask;
  wire [4:0] q_chan;
  wire [6:0] q_next, q_ctrl, q_slot;
  wire [7:0] q_subch, q_mask;
  wire q_en, q_cross, q_end;
  wire [15:0] xtx_now, xrx_now;
  wire [4:0] rd_list_sel;

  assign seq_mode = (mode_r == `FSA_MODE_SEQ);
  // channel, next and subchannel arrays follow the list index in sequence mode
  assign list_sel = seq_mode ? list_idx_r : fifo_sel_r;
  assign rd_list_sel = list_sel;
  assign seq_list_addr = idx_r;
  // fifo control is looked up by the fifo being served
  assign seq_ctrl_addr = seq_mode ? cur_r : idx_r;
  assign q_en = (q_ctrl[3:1] != 3'h0);
  assign q_cross = (q_ctrl[6:4] == `FSA_FLOW_CROSS);
  assign q_end = q_next[6];
  // reservations of this walk, the entry being served included
  assign xtx_now = xtx_pend_r |
    ({15'h0000, q_en & q_cross & ~seq_ctrl_addr[0]} << q_chan[4:1]);
  assign xrx_now = xrx_pend_r |
    ({15'h0000, q_en & q_cross & seq_ctrl_addr[0]} << q_chan[4:1]);

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_ok_r & ~s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  assign wr_go = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  // address and data latch in either order, response after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_idx_r <= 8'h00;
      w_data_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r <= 1'b1;
        w_data_r <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
      end
      if (wr_go)
      begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // plain registers, the 0x0f index is shared by fifo select and list index
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= `FSA_MODE_RST;
      fifo_sel_r <= 5'h00;
      list_idx_r <= 5'h00;
      first_r <= 5'h00;
      slot_sel_r <= 5'h00;
    end
    else if (wr_go)
    begin
      case (aw_idx_r)
        `FSA_IDX_MODE: mode_r <= w_data_r[1:0];
        `FSA_IDX_FIRST: first_r <= w_data_r[4:0];
        `FSA_IDX_FIFO_SEL: fifo_sel_r <= w_data_r[4:0];
        `FSA_IDX_SLOT_SEL: slot_sel_r <= w_data_r[4:0];
        `FSA_IDX_LIST:
        begin
          if (seq_mode)
            list_idx_r <= w_data_r[4:0];
          else
            fifo_sel_r <= w_data_r[4:0];
        end
        default: mode_r <= mode_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel, two cycles through the tables
  // ------------------------------------------------------------
  assign s_axi_arready = ~rd_pend_r & ~s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend_r <= 1'b0;
      ar_idx_r <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_pend_r <= 1'b1;
        ar_idx_r <= s_axi_araddr[9:2];
      end
      if (rd_pend_r)
      begin
        rd_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        case (ar_idx_r)
          `FSA_IDX_MODE: s_axi_rdata <= {30'h0, mode_r};
          `FSA_IDX_FIRST: s_axi_rdata <= {27'h0, first_r};
          `FSA_IDX_FIFO_SEL: s_axi_rdata <= {27'h0, fifo_sel_r};
          `FSA_IDX_SLOT_SEL: s_axi_rdata <= {27'h0, slot_sel_r};
          `FSA_IDX_STATUS: s_axi_rdata <= {22'h0, state_r, 3'h0, idx_r};
          `FSA_IDX_CHANNEL: s_axi_rdata <= {27'h0, b_chan};
          `FSA_IDX_NEXT: s_axi_rdata <= {24'h0, b_next[6], 2'h0, b_next[4:0]};
          `FSA_IDX_SUBCH: s_axi_rdata <= {24'h0, b_subch};
          `FSA_IDX_CTRL: s_axi_rdata <= {24'h0, b_ctrl[6:4], 1'b0, b_ctrl[3:0]};
          `FSA_IDX_CHMASK: s_axi_rdata <= {24'h0, b_mask};
          `FSA_IDX_SLOT: s_axi_rdata <= {24'h0, b_slot[6:5], 1'b0, b_slot[4:0]};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // tables
  // ------------------------------------------------------------
  // channel assignment per list entry: {ch[3:0], dir}
  fsa_mem #(.W(5), .RST(0)) u_chan (
    .aclk(aclk), .we(wr_go && aw_idx_r == `FSA_IDX_CHANNEL), .waddr(list_sel),
    .wdata(w_data_r[4:0]), .raddr_a(rd_list_sel), .rdata_a(b_chan),
    .raddr_b(seq_list_addr), .rdata_b(q_chan)
  );
  // next fifo per list entry: {end, pad, num[3:0], dir}
  fsa_mem #(.W(7), .RST(0)) u_next (
    .aclk(aclk), .we(wr_go && aw_idx_r == `FSA_IDX_NEXT), .waddr(list_sel),
    .wdata({w_data_r[`FSA_END_BIT], 1'b0, w_data_r[4:0]}),
    .raddr_a(rd_list_sel), .rdata_a(b_next), .raddr_b(seq_list_addr), .rdata_b(q_next)
  );
  // subchannel mask per list entry
  fsa_mem #(.W(8), .RST(`FSA_SUBCH_RST)) u_subch (
    .aclk(aclk), .we(wr_go && aw_idx_r == `FSA_IDX_SUBCH), .waddr(list_sel),
    .wdata(w_data_r[7:0]), .raddr_a(rd_list_sel), .rdata_a(b_subch),
    .raddr_b(seq_list_addr), .rdata_b(q_subch)
  );
  // fifo control, written and read back by fifo select, walked by the fifo served: {flow[2:0], enable[2:0], framing}
  fsa_mem #(.W(7), .RST(0)) u_ctrl (
    .aclk(aclk), .we(wr_go && aw_idx_r == `FSA_IDX_CTRL), .waddr(fifo_sel_r),
    .wdata({w_data_r[7:5], w_data_r[3:0]}), .raddr_a(fifo_sel_r), .rdata_a(b_ctrl),
    .raddr_b(seq_ctrl_addr), .rdata_b(q_ctrl)
  );
  // channel mask per switching channel, written while fifo select holds the channel
  fsa_mem #(.W(8), .RST(0)) u_mask (
    .aclk(aclk), .we(wr_go && aw_idx_r == `FSA_IDX_CHMASK), .waddr(fifo_sel_r),
    .wdata(w_data_r[7:0]), .raddr_a(fifo_sel_r), .rdata_a(b_mask),
    .raddr_b(q_chan), .rdata_b(q_mask)
  );
  // slot configuration: {route[1:0], ch[3:0], dir}
  fsa_mem #(.W(7), .RST(0)) u_slot (
    .aclk(aclk), .we(wr_go && aw_idx_r == `FSA_IDX_SLOT), .waddr(slot_sel_r),
    .wdata({w_data_r[7:6], w_data_r[4:0]}), .raddr_a(slot_sel_r), .rdata_a(b_slot),
    .raddr_b(pcm_slot_idx), .rdata_b(q_slot)
  );

  // ------------------------------------------------------------
  // frame timer
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_cnt_r <= 16'h0000;
      frame_tick_r <= 1'b0;
    end
    else
    begin
      frame_tick_r <= (frame_cnt_r == FRAME_CYCLES[15:0] - 16'h0001);
      if (frame_cnt_r == FRAME_CYCLES[15:0] - 16'h0001)
        frame_cnt_r <= 16'h0000;
      else
        frame_cnt_r <= frame_cnt_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // list walker: one entry per three cycles, once per frame
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= S_IDLE;
      idx_r <= 5'h00;
      cur_r <= 5'h00;
      seq_xfer <= 1'b0;
      seq_fifo_dir <= 1'b0;
      seq_fifo_num <= 4'h0;
      seq_chan_dir <= 1'b0;
      seq_chan <= 4'h0;
      seq_subch_mask <= 8'h00;
      seq_chan_mask <= 8'h00;
      seq_transparent <= 1'b0;
      xtx_pend_r <= 16'h0000;
      xrx_pend_r <= 16'h0000;
      cross_ok_r <= 16'h0000;
    end
    else
    begin
      seq_xfer <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (frame_tick_r)
          begin
            idx_r <= 5'h00;
            cur_r <= first_r;
            state_r <= S_RD;
          end
        end
        S_RD: state_r <= S_MSK;
        // entry channel is known now, its mask is looked up
        S_MSK: state_r <= S_USE;
        S_USE:
        begin
          // disabled fifos move no data
          seq_xfer <= q_en;
          seq_fifo_dir <= seq_ctrl_addr[0];
          seq_fifo_num <= seq_ctrl_addr[4:1];
          seq_chan_dir <= q_chan[0];
          seq_chan <= q_chan[4:1];
          seq_subch_mask <= q_subch;
          seq_chan_mask <= q_mask;
          seq_transparent <= q_ctrl[0];
          xtx_pend_r <= xtx_now;
          xrx_pend_r <= xrx_now;
          cur_r <= q_next[4:0];
          idx_r <= idx_r + 5'h01;
          if ((seq_mode && q_end) || idx_r == `FSA_LIST_LAST)
          begin
            // both reserved fifos must be enabled for the cross path
            cross_ok_r <= xtx_now & xrx_now;
            xtx_pend_r <= 16'h0000;
            xrx_pend_r <= 16'h0000;
            state_r <= S_IDLE;
          end
          else
            state_r <= S_RD;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // cross connection between pcm slots and the line interface
  // ------------------------------------------------------------
  // slot table read takes one cycle, strobe delayed to match
  always @(posedge aclk)
  begin
    if (!aresetn)
      slot_stb_r <= 1'b0;
    else
      slot_stb_r <= pcm_slot_strobe;
  end

  fsa_exchanger u_xchg (
    .aclk(aclk), .aresetn(aresetn), .slot_strobe(slot_stb_r), .slot_dir(q_slot[0]),
    .slot_pin_route(q_slot[6:5]), .cross_ok(cross_ok_r[q_slot[4:1]]),
    .line_rx_data(line_rx_data), .serial_data_pin_b(serial_data_pin_b),
    .serial_data_pin_a(serial_data_pin_a), .pin_a_valid(pin_a_valid),
    .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
    .fifo_rx_data(fifo_rx_data), .fifo_rx_wr(fifo_rx_wr)
  );
endmodule // fsa_assigner
`default_nettype wire

// *** testbench/fsa_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------
// cross path and sequencer checker
// ------
module fsa_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic seq_xfer,
  input wire logic pcm_slot_strobe,
  input wire logic [4:0] pcm_slot_idx,
  input wire logic [7:0] line_rx_data,
  input wire logic [7:0] serial_data_pin_b,
  input wire logic [7:0] serial_data_pin_a,
  input wire logic pin_a_valid,
  input wire logic [7:0] line_tx_data,
  input wire logic line_tx_valid,
  input wire logic [7:0] fifo_rx_data,
  input wire logic fifo_rx_wr
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // pin a output follows a transmit slot strobe two cycles on
  AST_A_TIME: assert property (pin_a_valid |-> $past(pcm_slot_strobe, 2))
    else $error("pin a pulse without slot strobe");
  AST_A_DIR: assert property (pin_a_valid |-> !$past(pcm_slot_idx[0], 2))
    else $error("pin a pulse for a receive slot");
  AST_A_DATA: assert property (pin_a_valid |-> serial_data_pin_a == $past(line_rx_data))
    else $error("pin a data is not line receive data");
  AST_L_TIME: assert property (line_tx_valid |->
    $past(pcm_slot_strobe, 2) && $past(pcm_slot_idx[0], 2))
    else $error("line transmit pulse without receive slot");
  AST_L_DATA: assert property (line_tx_valid |-> line_tx_data == $past(serial_data_pin_b))
    else $error("line transmit data is not pin b data");
  AST_COPY: assert property (pin_a_valid |-> fifo_rx_wr && fifo_rx_data == serial_data_pin_a)
    else $error("receive copy missing or different");
  AST_ONEWAY: assert property (pin_a_valid |-> !line_tx_valid)
    else $error("both directions in one cycle");
  AST_SPACING: assert property (seq_xfer |=> !seq_xfer [*2])
    else $error("list entries closer than three cycles");
  // main scenarios reached
  cover property (pin_a_valid);
  cover property (line_tx_valid);
  cover property (seq_xfer);
endmodule // fsa_monitor
bind fsa_assigner fsa_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .seq_xfer(seq_xfer),
  .pcm_slot_strobe(pcm_slot_strobe), .pcm_slot_idx(pcm_slot_idx),
  .line_rx_data(line_rx_data), .serial_data_pin_b(serial_data_pin_b),
  .serial_data_pin_a(serial_data_pin_a), .pin_a_valid(pin_a_valid),
  .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
  .fifo_rx_data(fifo_rx_data), .fifo_rx_wr(fifo_rx_wr));
`default_nettype wire

// *** testbench/fsa_slot_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------
// pcm slot bus and line interface side
// ------
module fsa_slot_model (
  input wire logic aclk,
  output logic pcm_slot_strobe,
  output logic [4:0] pcm_slot_idx,
  output logic [7:0] line_rx_data,
  output logic [7:0] serial_data_pin_b
);
  initial
  begin
    pcm_slot_strobe = 1'h0;
    pcm_slot_idx = 5'h00;
    line_rx_data = 8'h00;
    serial_data_pin_b = 8'h00;
  end
  // one strobe for a slot in use, data one cycle later, then lines go stale
  task automatic send(input logic [4:0] i, input logic [7:0] rx, input logic [7:0] b);
    @(posedge aclk);
    pcm_slot_strobe <= 1'h1;
    pcm_slot_idx <= i;
    @(posedge aclk);
    pcm_slot_strobe <= 1'h0;
    pcm_slot_idx <= ~i;
    line_rx_data <= rx;
    serial_data_pin_b <= b;
    @(posedge aclk);
    line_rx_data <= ~rx; // released: inverse of last value
    serial_data_pin_b <= ~b;
  endtask
endmodule // fsa_slot_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fsa_defines.vh"
module tb_top;
  localparam int F = 200;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rv;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, sx, sfd, scd, strb, pav, ltv, frw, stp;
  wire [1:0] br, rr;
  wire [31:0] rdata;
  wire [3:0] sfn, sch;
  wire [4:0] sidx;
  wire [7:0] ssm, scm, lrx, pinb, pa, lt, fr;
  int failures = 0, n_compared = 0, cyc = 0, na = 0, nl = 0, nf = 0;
  logic [7:0] pa_q, lt_q, fr_q;
  logic [26:0] sq [$];
  int ts [$];
  logic [26:0] ex [3] = '{{1'h0, 4'hc, 1'h0, 4'h2, 8'h00, 8'hff, 1'h0},
    {1'h0, 4'he, 1'h0, 4'h4, 8'h3c, 8'h00, 1'h1}, {1'h0, 4'he, 1'h0, 4'h5, 8'hc3, 8'h00, 1'h1}};
  logic [7:0] chv [3] = '{8'h04, 8'h08, 8'h0a};
  logic [7:0] smv [3] = '{8'h00, 8'h3c, 8'hc3};
  logic [7:0] nxv [3] = '{8'h1c, 8'h1c, 8'h80};
  logic [7:0] fsv [3] = '{8'h18, 8'h1c, 8'h1c};
  fsa_assigner #(.FRAME_CYCLES(F)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(br), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .seq_xfer(sx), .seq_fifo_dir(sfd), .seq_fifo_num(sfn), .seq_chan_dir(scd),
    .seq_chan(sch), .seq_subch_mask(ssm), .seq_chan_mask(scm), .seq_transparent(stp),
    .pcm_slot_strobe(strb), .pcm_slot_idx(sidx), .line_rx_data(lrx),
    .serial_data_pin_b(pinb), .serial_data_pin_a(pa), .pin_a_valid(pav),
    .line_tx_data(lt), .line_tx_valid(ltv), .fifo_rx_data(fr), .fifo_rx_wr(frw));
  fsa_slot_model pm_u (.aclk(aclk), .pcm_slot_strobe(strb), .pcm_slot_idx(sidx),
    .line_rx_data(lrx), .serial_data_pin_b(pinb));
  // ------
  // clock, output capture and hang limit
  // ------
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (pav) na <= na + 1;
    if (pav) pa_q <= pa;
    if (ltv) nl <= nl + 1;
    if (ltv) lt_q <= lt;
    if (frw) nf <= nf + 1;
    if (frw) fr_q <= fr;
    if (sx) sq.push_back({sfd, sfn, scd, sch, ssm, scm, stp});
    if (sx) ts.push_back(cyc);
    if (cyc == 10000)
    begin
      failures = failures + 1;
      conclude();
    end
  end
  // ------
  // tasks
  // ------
  task automatic conclude;
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // register write, address and data offered together
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    chk("write response", 32'h0, {30'h0, br});
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d);
    @(posedge aclk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    d = rdata;
    chk("read response", 32'h0, {30'h0, rr});
    rready <= 1'h0;
  endtask
  // one slot transfer, then count pulses on each output
  task automatic slot(input logic [4:0] i, input logic [7:0] rx, input logic [7:0] b,
    input logic [31:0] ea, input logic [31:0] el);
    int a0, l0, f0;
    a0 = na;
    l0 = nl;
    f0 = nf;
    pm_u.send(i, rx, b);
    repeat (4) @(posedge aclk);
    chk("pin a pulses", ea, na - a0);
    chk("line tx pulses", el, nl - l0);
    chk("fifo copy writes", ea, nf - f0);
  endtask
  // ------
  // main sequence
  // ------
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    wr(`FSA_IDX_LIST, 8'h07);
    rd(`FSA_IDX_LIST, rv);
    chk("list index read", 32'h0, rv);
    rd(8'h20, rv);
    chk("unmapped read", 32'h0, rv);
    // cross connection: tx fifo transparent, rx fifo framed
    wr(`FSA_IDX_FIFO_SEL, 8'h0a);
    wr(`FSA_IDX_CTRL, 8'hcf);
    wr(`FSA_IDX_CHANNEL, 8'h02);
    wr(`FSA_IDX_FIFO_SEL, 8'h0b);
    wr(`FSA_IDX_CTRL, 8'hce);
    wr(`FSA_IDX_CHANNEL, 8'h03);
    wr(`FSA_IDX_SLOT_SEL, 8'h0e);
    wr(`FSA_IDX_SLOT, 8'h82);
    wr(`FSA_IDX_SLOT_SEL, 8'h0f);
    wr(`FSA_IDX_SLOT, 8'h83);
    repeat (2 * F) @(posedge aclk);
    slot(5'h0e, 8'h5a, 8'h11, 1, 0);
    chk("pin a data", 8'h5a, pa_q);
    chk("fifo copy data", 8'h5a, fr_q);
    slot(5'h0f, 8'h22, 8'ha5, 0, 1);
    chk("line tx data", 8'ha5, lt_q);
    // other pin route passes nothing
    wr(`FSA_IDX_SLOT_SEL, 8'h0e);
    wr(`FSA_IDX_SLOT, 8'h42);
    slot(5'h0e, 8'h33, 8'h44, 0, 0);
    wr(`FSA_IDX_SLOT, 8'h82);
    // rx fifo disabled stops the path
    wr(`FSA_IDX_FIFO_SEL, 8'h0b);
    wr(`FSA_IDX_CTRL, 8'hc0);
    repeat (2 * F) @(posedge aclk);
    slot(5'h0e, 8'h66, 8'h77, 0, 0);
    // sequence list: fifo 12 once, fifo 14 on two channels
    wr(`FSA_IDX_MODE, 8'h03);
    wr(`FSA_IDX_FIRST, 8'h18);
    for (int k = 0; k < 3; k++)
    begin
      wr(`FSA_IDX_LIST, k[7:0]);
      wr(`FSA_IDX_CHANNEL, chv[k]);
      wr(`FSA_IDX_SUBCH, smv[k]);
      wr(`FSA_IDX_NEXT, nxv[k]);
      wr(`FSA_IDX_FIFO_SEL, fsv[k]);
      wr(`FSA_IDX_CTRL, {7'h07, k != 0});
    end
    wr(`FSA_IDX_FIFO_SEL, 8'h04);
    wr(`FSA_IDX_CHMASK, 8'hff);
    repeat (2 * F) @(posedge aclk);
    // align to the end of one walk, then watch two frames
    sq.delete();
    while (sq.size() == 0) @(posedge aclk);
    repeat (20) @(posedge aclk);
    sq.delete();
    ts.delete();
    repeat (2 * F) @(posedge aclk);
    chk("entries in two frames", 6, sq.size());
    for (int k = 0; k < 6; k++)
      chk("list entry", {5'h0, ex[k % 3]}, {5'h0, sq[k]});
    chk("frame spacing", F, ts[3] - ts[0]);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
